// ---- verilog/vsoc_pkg.sv ----
// package: constants and carriers for the setpoint and overvoltage control
package vsoc_pkg;
  // register offsets (word index equals byte address / 4)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SETPOINT = 8'h04;
  localparam logic [7:0] REG_OV_CFG = 8'h08;
  localparam logic [7:0] REG_COEF = 8'h0C;
  localparam logic [7:0] REG_NLR = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_IRQ_STAT = 8'h18;
  localparam logic [7:0] REG_IRQ_MASK = 8'h1C;
  localparam logic [7:0] REG_NV_ADDR = 8'h20;
  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_TUNE_BIT = 1;
  localparam int CTRL_SAVE_BIT = 2;
  localparam int OVCFG_MODE_LSB = 0;
  localparam int OVCFG_RETRY_LSB = 4;
  localparam int OVCFG_PCT_LSB = 8;
  // interrupt bits
  localparam int IRQ_OV = 0;
  localparam int IRQ_REJECT = 1;
  localparam int IRQ_INIT = 2;
  localparam int IRQ_RETRY_OUT = 3;
  // setpoint in millivolts, 16 bits
  localparam logic [15:0] MV_STRAP_SHORT = 16'h0258; // 600
  localparam logic [15:0] MV_STRAP_OPEN = 16'h04B0; // 1200
  localparam logic [15:0] MV_STRAP_HIGH = 16'h09C4; // 2500
  localparam logic [15:0] MV_MIN = 16'h00C8; // 200, lower limit when enabled
  // reset values and strap limits
  localparam logic [7:0] OV_PCT_RST = 8'h0F; // 15 percent
  localparam logic [3:0] OV_RETRY_RST = 4'h3;
  localparam logic [31:0] NLR_RST = 32'h0000_0000;
  localparam logic [31:0] COEF_SAFE = 32'h0000_0000;
  localparam int MAX_PCT = 110;
  localparam int STRAP_LEVELS = 28;
  // restart delay
  localparam int RESTART_US = 100;
  localparam int CLK_MHZ = 25;
  localparam int RESTART_CYC = RESTART_US * CLK_MHZ;

  typedef enum logic [1:0] {
    OV_SHUTDOWN_RETRY,
    OV_CROWBAR,
    OV_HICCUP_DEFAULT
  } vsoc_ov_mode_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } vsoc_bus_s;

  typedef struct packed {
    logic hs_en;
    logic ls_force;
  } vsoc_drive_s;
endpackage : vsoc_pkg

// ---- verilog/vsoc_top.sv ----
// setpoint decode, setpoint limiting and overvoltage response logic
// What this block does
// - tuning off: load user coefficients, run with them
// - strap resistor code maps to 28 voltages
// - strap sampled only during start-up
// - short/open/high straps select 0.6/1.2/2.5 V
// - bus command replaces strap setpoint within limits
// - bus and user setpoints capped at 110 percent of resistor strap, at strap value for short/open/high
// - enabled: ceiling from bin at enable time
// - disabled: only strap-derived maximum applies
// - overvoltage detected at 15 percent above setpoint
// - shutdown mode retries restart limited times
// - crowbar mode holds low side until restart
// - default: shut down, restart once fault clears
// - external sync forces default shut-down-and-restart response
// - threshold and response reprogrammable over bus
// - transient loop settings writable, preset defaults
// - init order strap, factory, user; each overwrites, user setpoint only if within strap maximum
module vsoc_top (
  input wire logic i_clk, // 25 MHz clock
  input wire logic i_nrst, // async reset, active low
  input wire logic i_ce, // clock enable
  input wire logic [7:0] i_addr, // register address
  input wire logic [31:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  input wire logic [1:0] i_strap_state, // 0 res,1 short,2 open,3 high
  input wire logic [4:0] i_strap_code, // resistor level 0..27
  input wire logic [15:0] i_vout_mv, // measured output, mV
  input wire logic i_ext_sync, // switching on external sync
  input wire logic [31:0] i_nv_data, // nonvolatile read data
  input wire logic i_nv_factory_ok, // factory image holds a setpoint
  input wire logic i_nv_user_ok, // user image holds a setpoint
  output logic [31:0] o_rdata, // read data, cycle after strobe
  output logic o_irq, // interrupt level
  output logic o_hs_en, // high-side switch drive allowed
  output logic o_ls_force, // low-side switch held on
  output logic [15:0] o_setpoint_mv, // regulated setpoint
  output logic [31:0] o_coef, // working compensator coefficients
  output logic [31:0] o_nlr, // transient loop settings
  output logic [1:0] o_nv_sel, // 1 factory, 2 user image read
  output logic o_nv_save // pulse: save working values
);
  // ----------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) rst_sync_r <= 2'h0;
    else rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // no reset: the pins fill the stages while reset is held, so the strap
  // stage right after release sees the real pin state, not zeros
  logic [23:0] pin_s1_r, pin_s2_r;
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      pin_s1_r <= {i_ext_sync, i_strap_state, i_strap_code, i_vout_mv};
      pin_s2_r <= pin_s1_r;
    end
  end
  logic ext_sync;
  logic [1:0] strap_state;
  logic [4:0] strap_code;
  logic [15:0] vout_mv;
  assign {ext_sync, strap_state, strap_code, vout_mv} = pin_s2_r;

  // ----------------------------------------
  // strap decode
  // ----------------------------------------
  function automatic logic [15:0] strap_mv(input logic [4:0] c);
    logic [15:0] v;
    v = 16'h0258;
    if (c <= 5'h0D) v = 16'(16'h0258 + 16'(c) * 16'h0032); // 0.60..1.25
    else if (c == 5'h0E) v = 16'h0514; // 1.30
    else if (c <= 5'h18) v = 16'(16'h0578 + 16'(c - 5'h0F) * 16'h0064);
    else if (c == 5'h19) v = 16'h09C4; // 2.50
    else if (c == 5'h1A) v = 16'h0BB8; // 3.00
    else v = 16'h0CE4; // 3.30
    return v;
  endfunction : strap_mv

  function automatic logic [15:0] bin_ceil(input logic [15:0] mv);
    logic [15:0] v;
    if (mv < 16'h03DC) v = 16'h04B0; // below 0.988 -> 1.2
    else if (mv < 16'h0567) v = 16'h06A4; // -> 1.7
    else if (mv < 16'h07B7) v = 16'h09C4; // -> 2.5
    else if (mv < 16'h095E) v = 16'h0B9A; // -> 2.97
    else if (mv < 16'h0B93) v = 16'h0E60; // -> 3.68
    else v = 16'h1229; // -> 4.65
    return v;
  endfunction : bin_ceil

  // ----------------------------------------
  // initialisation sequence
  // ----------------------------------------
  typedef enum logic [2:0] {
    INIT_STRAP, INIT_FACTORY, INIT_USER, INIT_DONE
  } vsoc_init_e;
  vsoc_init_e init_r;
  logic [15:0] nominal_r, vmax_r;
  logic [15:0] setpoint_r;
  logic [31:0] coef_r, nlr_r;
  logic tune_r, en_r, en_d_r;
  logic [15:0] enable_ceil_r;
  logic bus_wr_sp, bus_reject;
  logic init_done_ev;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) init_r <= INIT_STRAP;
    else if (i_ce) begin
      case (init_r)
        INIT_STRAP: init_r <= INIT_FACTORY;
        INIT_FACTORY: init_r <= INIT_USER;
        INIT_USER: init_r <= INIT_DONE;
        INIT_DONE: init_r <= INIT_DONE;
        default: init_r <= INIT_STRAP;
      endcase
    end
  end
  assign init_done_ev = i_ce && (init_r == INIT_USER);

  // strap sampled once; later resistor changes are ignored
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      nominal_r <= vsoc_pkg::MV_STRAP_OPEN;
      vmax_r <= vsoc_pkg::MV_STRAP_OPEN;
    end else if (i_ce && init_r == INIT_STRAP) begin
      case (strap_state)
        2'h1: begin
          nominal_r <= vsoc_pkg::MV_STRAP_SHORT;
          vmax_r <= vsoc_pkg::MV_STRAP_SHORT;
        end
        2'h2: begin
          nominal_r <= vsoc_pkg::MV_STRAP_OPEN;
          vmax_r <= vsoc_pkg::MV_STRAP_OPEN;
        end
        2'h3: begin
          nominal_r <= vsoc_pkg::MV_STRAP_HIGH;
          vmax_r <= vsoc_pkg::MV_STRAP_HIGH;
        end
        default: begin
          nominal_r <= strap_mv(strap_code);
          vmax_r <= 16'((32'(strap_mv(strap_code)) * vsoc_pkg::MAX_PCT)
                        / 100);
        end
      endcase
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  logic [15:0] sp_req;
  logic [15:0] sp_lim;
  logic [1:0] ov_mode_r;
  logic [3:0] ov_retry_r;
  logic [7:0] ov_pct_r;
  logic [3:0] irq_stat_r, irq_mask_r;
  logic save_pulse_r;
  logic wr_hit;
  assign wr_hit = i_ce && i_wr;
  assign sp_req = i_wdata[15:0];
  assign sp_lim = en_r ? ((enable_ceil_r < vmax_r) ? enable_ceil_r : vmax_r)
                       : vmax_r;
  assign bus_wr_sp = wr_hit && i_addr == vsoc_pkg::REG_SETPOINT;
  assign bus_reject = bus_wr_sp && (sp_req > sp_lim ||
                      (en_r && sp_req < vsoc_pkg::MV_MIN));

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) setpoint_r <= vsoc_pkg::MV_STRAP_OPEN;
    else if (i_ce) begin
      if (init_r == INIT_FACTORY) begin
        if (i_nv_factory_ok) setpoint_r <= i_nv_data[15:0];
        else setpoint_r <= nominal_r;
      end else if (init_r == INIT_USER && i_nv_user_ok) begin
        if (i_nv_data[15:0] <= vmax_r) setpoint_r <= i_nv_data[15:0];
      end else if (bus_wr_sp && !bus_reject) begin
        setpoint_r <= sp_req;
      end
    end
  end

  // bin of the setpoint fixed at the enable edge
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) enable_ceil_r <= 16'h0000;
    else if (i_ce && wr_hit && i_addr == vsoc_pkg::REG_CTRL &&
             init_r == INIT_DONE && !en_r &&
             i_wdata[vsoc_pkg::CTRL_EN_BIT])
      enable_ceil_r <= bin_ceil(setpoint_r);
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_r <= 1'b0;
      tune_r <= 1'b0;
      en_d_r <= 1'b0;
      save_pulse_r <= 1'b0;
    end else if (i_ce) begin
      en_d_r <= en_r;
      save_pulse_r <= wr_hit && i_addr == vsoc_pkg::REG_CTRL &&
                      i_wdata[vsoc_pkg::CTRL_SAVE_BIT];
      if (wr_hit && i_addr == vsoc_pkg::REG_CTRL && init_r == INIT_DONE) begin
        en_r <= i_wdata[vsoc_pkg::CTRL_EN_BIT];
        tune_r <= i_wdata[vsoc_pkg::CTRL_TUNE_BIT];
      end
    end
  end

  // coefficients: safe start, then user image if present; tune_r is still clear at init
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) coef_r <= vsoc_pkg::COEF_SAFE;
    else if (i_ce) begin
      if (init_r == INIT_FACTORY) coef_r <= vsoc_pkg::COEF_SAFE;
      else if (init_r == INIT_USER && !tune_r && i_nv_user_ok)
        coef_r <= i_nv_data;
      else if (wr_hit && i_addr == vsoc_pkg::REG_COEF)
        coef_r <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) nlr_r <= vsoc_pkg::NLR_RST;
    else if (i_ce && wr_hit && i_addr == vsoc_pkg::REG_NLR)
      nlr_r <= i_wdata;
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ov_mode_r <= 2'(vsoc_pkg::OV_HICCUP_DEFAULT);
      ov_retry_r <= vsoc_pkg::OV_RETRY_RST;
      ov_pct_r <= vsoc_pkg::OV_PCT_RST;
    end else if (i_ce && wr_hit && i_addr == vsoc_pkg::REG_OV_CFG) begin
      ov_mode_r <= i_wdata[vsoc_pkg::OVCFG_MODE_LSB +: 2];
      ov_retry_r <= i_wdata[vsoc_pkg::OVCFG_RETRY_LSB +: 4];
      ov_pct_r <= i_wdata[vsoc_pkg::OVCFG_PCT_LSB +: 8];
    end
  end

  // ----------------------------------------
  // overvoltage response
  // ----------------------------------------
  typedef enum logic [1:0] {OV_RUN, OV_OFF, OV_WAIT} vsoc_ovst_e;
  vsoc_ovst_e ov_st_r;
  logic [15:0] ov_limit;
  logic ov_now;
  logic [15:0] wait_cnt_r;
  logic [3:0] tries_r;
  logic ov_ev, give_up_ev;
  logic [1:0] eff_mode;
  logic hs_r, ls_r;
  assign ov_limit = 16'(setpoint_r + 16'((32'(setpoint_r) * ov_pct_r) / 100));
  assign ov_now = vout_mv > ov_limit;
  assign eff_mode = ext_sync ? 2'(vsoc_pkg::OV_HICCUP_DEFAULT)
                             : ov_mode_r;
  assign ov_ev = i_ce && ov_st_r == OV_RUN && en_r && ov_now;
  assign give_up_ev = i_ce && ov_st_r == OV_WAIT && !ov_now &&
                      wait_cnt_r == 16'h0 &&
                      eff_mode == 2'(vsoc_pkg::OV_SHUTDOWN_RETRY) &&
                      tries_r == 4'h0;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ov_st_r <= OV_RUN;
      wait_cnt_r <= 16'h0;
      tries_r <= 4'h0;
      hs_r <= 1'b0;
      ls_r <= 1'b0;
    end else if (i_ce) begin
      case (ov_st_r)
        OV_RUN: begin
          hs_r <= en_r && init_r == INIT_DONE;
          ls_r <= 1'b0;
          if (!en_r) tries_r <= ov_retry_r;
          if (ov_ev) begin
            hs_r <= 1'b0;
            ls_r <= eff_mode == 2'(vsoc_pkg::OV_CROWBAR);
            wait_cnt_r <= 16'(vsoc_pkg::RESTART_CYC);
            ov_st_r <= OV_WAIT;
          end
        end
        OV_WAIT: begin
          if (wait_cnt_r != 16'h0) wait_cnt_r <= 16'(wait_cnt_r - 16'h1);
          else if (!ov_now) begin
            ls_r <= 1'b0;
            if (eff_mode == 2'(vsoc_pkg::OV_SHUTDOWN_RETRY)) begin
              if (tries_r == 4'h0) ov_st_r <= OV_OFF;
              else begin
                tries_r <= 4'(tries_r - 4'h1);
                ov_st_r <= OV_RUN;
              end
            end else ov_st_r <= OV_RUN;
          end
        end
        OV_OFF: begin
          hs_r <= 1'b0;
          ls_r <= 1'b0;
          if (!en_r) ov_st_r <= OV_RUN;
        end
        default: ov_st_r <= OV_RUN;
      endcase
    end
  end

  // ----------------------------------------
  // interrupts and read data
  // ----------------------------------------
  logic [3:0] irq_set, irq_clr;
  assign irq_set = {give_up_ev, init_done_ev, bus_reject, ov_ev};
  assign irq_clr = (wr_hit && i_addr == vsoc_pkg::REG_IRQ_STAT) ?
                   i_wdata[3:0] : 4'h0;
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= 4'h0;
      irq_mask_r <= 4'h0;
    end else if (i_ce) begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set; // set wins
      if (wr_hit && i_addr == vsoc_pkg::REG_IRQ_MASK)
        irq_mask_r <= i_wdata[3:0];
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) o_rdata <= 32'h0;
    else if (i_ce) begin
      o_rdata <= 32'h0;
      if (i_rd) begin
        case (i_addr)
          vsoc_pkg::REG_CTRL: o_rdata <= {30'h0, tune_r, en_r};
          vsoc_pkg::REG_SETPOINT: o_rdata <= {vmax_r, setpoint_r};
          vsoc_pkg::REG_OV_CFG:
            o_rdata <= {16'h0, ov_pct_r, ov_retry_r, 2'h0, ov_mode_r};
          vsoc_pkg::REG_COEF: o_rdata <= coef_r;
          vsoc_pkg::REG_NLR: o_rdata <= nlr_r;
          vsoc_pkg::REG_STATUS:
            o_rdata <= {nominal_r, 8'h0, tries_r, ov_now, ext_sync,
                        ov_st_r};
          vsoc_pkg::REG_IRQ_STAT: o_rdata <= {28'h0, irq_stat_r};
          vsoc_pkg::REG_IRQ_MASK: o_rdata <= {28'h0, irq_mask_r};
          default: o_rdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_irq <= 1'b0;
      o_hs_en <= 1'b0;
      o_ls_force <= 1'b0;
      o_setpoint_mv <= vsoc_pkg::MV_STRAP_OPEN;
      o_coef <= vsoc_pkg::COEF_SAFE;
      o_nlr <= vsoc_pkg::NLR_RST;
      o_nv_sel <= 2'h0;
      o_nv_save <= 1'b0;
    end else if (i_ce) begin
      o_irq <= |(irq_stat_r & irq_mask_r);
      o_hs_en <= hs_r;
      o_ls_force <= ls_r;
      o_setpoint_mv <= setpoint_r;
      o_coef <= coef_r;
      o_nlr <= nlr_r;
      o_nv_sel <= init_r == INIT_STRAP ? 2'h1 :
                  init_r == INIT_FACTORY ? 2'h2 : 2'h0;
      o_nv_save <= save_pulse_r;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_reject_keeps_sp:
    assert property (@(posedge i_clk) disable iff (!rst_n)
      (bus_reject && init_r == INIT_DONE) |=> $stable(setpoint_r))
    else $error("rejected setpoint changed the value");
  a_accept_sp:
    assert property (@(posedge i_clk) disable iff (!rst_n)
      (bus_wr_sp && !bus_reject && init_r == INIT_DONE)
      |=> setpoint_r == $past(sp_req))
    else $error("accepted setpoint not applied");
  a_max_limit:
    assert property (@(posedge i_clk) disable iff (!rst_n)
      init_r == INIT_DONE && $past(init_r) == INIT_DONE
      |-> setpoint_r <= vmax_r)
    else $error("setpoint above strap maximum");
  a_enabled_ceil:
    assert property (@(posedge i_clk) disable iff (!rst_n)
      (bus_wr_sp && en_r && en_d_r && sp_req > enable_ceil_r) |-> bus_reject)
    else $error("enabled ceiling not enforced");
  a_disabled_lim:
    assert property (@(posedge i_clk) disable iff (!rst_n)
      (bus_wr_sp && !en_r && sp_req <= vmax_r) |-> !bus_reject)
    else $error("disabled write wrongly rejected");
  a_ov_shut:
    assert property (@(posedge i_clk) disable iff (!rst_n)
      ov_ev |=> !hs_r ##1 !o_hs_en)
    else $error("overvoltage did not stop high side");
  a_crowbar:
    assert property (@(posedge i_clk) disable iff (!rst_n)
      (ov_ev && eff_mode == 2'(vsoc_pkg::OV_CROWBAR)) |=> ls_r)
    else $error("crowbar not applied");
  a_sync_no_crowbar:
    assert property (@(posedge i_clk) disable iff (!rst_n)
      (ov_ev && ext_sync) |=> !ls_r)
    else $error("crowbar used under external sync");
  a_strap_frozen:
    assert property (@(posedge i_clk) disable iff (!rst_n)
      init_r == INIT_DONE |=> $stable(nominal_r))
    else $error("strap value changed after start-up");
  c_reject: cover property (@(posedge i_clk) bus_reject);
  c_ov: cover property (@(posedge i_clk) ov_ev);
  c_give_up: cover property (@(posedge i_clk) give_up_ev);
endmodule : vsoc_top

// ---- verif/vsoc_host_model.sv ----
// host model that drives the register port of the setpoint control block
module vsoc_host_model (
  input wire logic i_clk, // block clock
  input wire logic [31:0] i_rdata, // read data from the block
  output vsoc_pkg::vsoc_bus_s o_bus // address, data and strobes
);
  timeunit 1ns;
  timeprecision 1ps;

  initial o_bus = '0;

  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_bus.addr <= a;
    o_bus.wdata <= d;
    o_bus.wr <= 1'b1;
    @(posedge i_clk);
    o_bus.wr <= 1'b0;
    o_bus.wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    o_bus.addr <= a;
    o_bus.rd <= 1'b1;
    @(posedge i_clk);
    o_bus.rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask : rd

  // coefficients first, then the save command
  task automatic save_coef(input logic [31:0] c);
    wr(vsoc_pkg::REG_COEF, c);
    wr(vsoc_pkg::REG_CTRL, 32'h0000_0004);
  endtask : save_coef

  // let the input supply settle before tuning starts
  task automatic start_tuning();
    repeat (50) @(posedge i_clk);
    wr(vsoc_pkg::REG_CTRL, 32'h0000_0002);
  endtask : start_tuning
endmodule : vsoc_host_model

// ---- verif/tb.sv ----
// self-checking bench for the setpoint and overvoltage control block
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, nrst, ext_sync, nv_u_ok, irq, hs_en, ls_force, nv_save;
  logic [1:0] strap_state, nv_sel;
  logic [4:0] strap_code;
  logic [15:0] vout, sp;
  logic [31:0] nv_data, rdata, coef, nonlinear_transient_loop, d;
  vsoc_pkg::vsoc_bus_s bus;
  int mismatches, samples_checked, k;

  vsoc_host_model host (
    .i_clk(clk),
    .i_rdata(rdata),
    .o_bus(bus)
  );

  vsoc_top DUT (
    .i_clk(clk), .i_nrst(nrst), .i_ce(1'b1),
    .i_addr(bus.addr), .i_wdata(bus.wdata),
    .i_wr(bus.wr), .i_rd(bus.rd),
    .i_strap_state(strap_state), .i_strap_code(strap_code),
    .i_vout_mv(vout), .i_ext_sync(ext_sync), .i_nv_data(nv_data),
    .i_nv_factory_ok(1'b0), .i_nv_user_ok(nv_u_ok),
    .o_rdata(rdata), .o_irq(irq), .o_hs_en(hs_en),
    .o_ls_force(ls_force), .o_setpoint_mv(sp), .o_coef(coef),
    .o_nlr(nonlinear_transient_loop), .o_nv_sel(nv_sel), .o_nv_save(nv_save)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("mismatches %0d samples_checked %0d", mismatches,
      samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wait_hs(input logic v, input int lim, output int n);
    n = 0;
    while (hs_en !== v && n < lim) begin
      cyc(1);
      n++;
    end
    if (n >= lim) begin
      mismatches++;
      print_verdict();
    end
  endtask : wait_hs

  task automatic do_reset(input logic [1:0] s, input logic [4:0] c,
    input logic u);
    @(posedge clk);
    nrst <= 1'b0;
    strap_state <= s;
    strap_code <= c;
    nv_u_ok <= u;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    cyc(12);
  endtask : do_reset

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_defaults();
    chk(32'(sp), 32'h0000_03E8);
    host.rd(vsoc_pkg::REG_SETPOINT, d);
    chk(d, 32'h044C_03E8);
    host.rd(vsoc_pkg::REG_OV_CFG, d);
    chk(d, 32'h0000_0F32);
    host.rd(vsoc_pkg::REG_NLR, d);
    chk(d, 32'h0000_0000);
    host.rd(vsoc_pkg::REG_NV_ADDR, d);
    chk(d, 32'h0000_0000);
  endtask : t_defaults

  task automatic t_direct();
    logic [15:0] nom [3];
    nom[0] = 16'h0258;
    nom[1] = 16'h04B0;
    nom[2] = 16'h09C4;
    for (int s = 1; s < 4; s++) begin
      do_reset(2'(s), 5'h1B, 1'b0);
      host.rd(vsoc_pkg::REG_SETPOINT, d);
      chk(d, {2{nom[s - 1]}});
    end
  endtask : t_direct

  task automatic t_nv_user();
    do_reset(2'h0, 5'h08, 1'b1);
    chk(32'(sp), 32'h0000_0384);
    chk(coef, 32'h1234_0384);
    strap_code <= 5'h1B;
    cyc(10);
    chk(32'(sp), 32'h0000_0384);
  endtask : t_nv_user

  task automatic t_limits();
    do_reset(2'h0, 5'h08, 1'b0);
    host.wr(vsoc_pkg::REG_SETPOINT, 32'h0000_044C);
    cyc(3);
    chk(32'(sp), 32'h0000_044C);
    host.wr(vsoc_pkg::REG_SETPOINT, 32'h0000_044D);
    cyc(3);
    chk(32'(sp), 32'h0000_044C);
    host.rd(vsoc_pkg::REG_IRQ_STAT, d);
    chk(d, 32'h0000_0006);
    host.wr(vsoc_pkg::REG_IRQ_MASK, 32'h0000_0002);
    cyc(3);
    chk(32'(irq), 32'h1);
    host.wr(vsoc_pkg::REG_IRQ_STAT, 32'h0000_0002);
    cyc(3);
    chk(32'(irq), 32'h0);
  endtask : t_limits

  task automatic t_ceiling();
    do_reset(2'h0, 5'h1B, 1'b0);
    host.wr(vsoc_pkg::REG_SETPOINT, 32'h0000_03E8);
    host.wr(vsoc_pkg::REG_CTRL, 32'h0000_0001);
    host.wr(vsoc_pkg::REG_SETPOINT, 32'h0000_0708);
    cyc(3);
    chk(32'(sp), 32'h0000_03E8);
    host.wr(vsoc_pkg::REG_SETPOINT, 32'h0000_0672);
    cyc(3);
    chk(32'(sp), 32'h0000_0672);
    host.wr(vsoc_pkg::REG_CTRL, 32'h0000_0000);
    host.wr(vsoc_pkg::REG_SETPOINT, 32'h0000_0E10);
    cyc(3);
    chk(32'(sp), 32'h0000_0E10);
  endtask : t_ceiling

  task automatic t_coef_nlr();
    host.save_coef(32'hA5C3_0F96);
    k = 0;
    while (nv_save !== 1'b1 && k < 10) begin
      cyc(1);
      k++;
    end
    chk(32'(nv_save), 32'h1);
    chk(coef, 32'hA5C3_0F96);
    host.wr(vsoc_pkg::REG_NLR, 32'h3C5A_7E81);
    host.rd(vsoc_pkg::REG_NLR, d);
    chk(d, 32'h3C5A_7E81);
    chk(nonlinear_transient_loop, 32'h3C5A_7E81);
  endtask : t_coef_nlr

  // trips just above lim, drops the output, then times the restart
  task automatic ov_case(input logic [31:0] cfg, input logic [15:0] lim,
    input logic sync, input logic ls);
    ext_sync <= sync;
    vout <= 16'h03E8;
    host.wr(vsoc_pkg::REG_OV_CFG, cfg);
    host.wr(vsoc_pkg::REG_CTRL, 32'h0000_0001);
    wait_hs(1'b1, 20, k);
    vout <= lim;
    cyc(10);
    chk(32'(hs_en), 32'h1);
    vout <= lim + 16'h0001;
    wait_hs(1'b0, 20, k);
    cyc(2);
    chk(32'(ls_force), 32'(ls));
    vout <= 16'h03E8;
    wait_hs(1'b1, 3000, k);
    chk(32'(k > 2400), 32'h1);
    host.wr(vsoc_pkg::REG_CTRL, 32'h0000_0000);
    cyc(5);
  endtask : ov_case

  task automatic t_overvolt();
    do_reset(2'h0, 5'h08, 1'b0);
    ov_case(32'h0000_0F32, 16'h047E, 1'b0, 1'b0);
    ov_case(32'h0000_0F31, 16'h047E, 1'b0, 1'b1);
    ov_case(32'h0000_0F31, 16'h047E, 1'b1, 1'b0);
    ov_case(32'h0000_0532, 16'h041A, 1'b0, 1'b0);
    ext_sync <= 1'b0;
    host.wr(vsoc_pkg::REG_OV_CFG, 32'h0000_0F00);
    host.wr(vsoc_pkg::REG_CTRL, 32'h0000_0001);
    wait_hs(1'b1, 20, k);
    vout <= 16'h04B0;
    wait_hs(1'b0, 20, k);
    vout <= 16'h03E8;
    cyc(3000);
    chk(32'(hs_en), 32'h0);
    host.rd(vsoc_pkg::REG_IRQ_STAT, d);
    chk(d & 32'h0000_0008, 32'h0000_0008);
  endtask : t_overvolt

  initial begin
    mismatches = 0;
    samples_checked = 0;
    nrst = 1'b0;
    strap_state = 2'h0;
    strap_code = 5'h08;
    vout = 16'h0000;
    ext_sync = 1'b0;
    nv_u_ok = 1'b0;
    nv_data = 32'h1234_0384;
    do_reset(2'h0, 5'h08, 1'b0);
    t_defaults();
    t_direct();
    t_nv_user();
    t_limits();
    t_ceiling();
    t_coef_nlr();
    t_overvolt();
    host.start_tuning();
    print_verdict();
  end
endmodule : tb
